// ---- include/tcdc_defs.svh ----
`ifndef TCDC_DEFS_SVH
`define TCDC_DEFS_SVH
// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define TCDC_IDX_CHAN0_SOURCE_ADDRESS 8'h20
`define TCDC_IDX_CHAN0_DEST_ADDRESS 8'h23
`define TCDC_IDX_CHAN0_BYTE_COUNT 8'h26
`define TCDC_IDX_CHAN1_MEMORY_ADDRESS 8'h28
`define TCDC_IDX_CHAN1_IO_ADDRESS 8'h2B
`define TCDC_IDX_CHAN1_BYTE_COUNT 8'h2E
`define TCDC_IDX_STAT 8'h30
`define TCDC_IDX_MODE 8'h31
`define TCDC_IDX_WCTL 8'h32
// ----------------------------------------------------------------
// Status/enable bits
// ----------------------------------------------------------------
`define TCDC_ST_DE0   6
`define TCDC_ST_WE0   4
`define TCDC_ST_CHAN0_TERM_IRQ_ENABLE  2
`define TCDC_ST_DME   0
// ----------------------------------------------------------------
// Mode and wait control fields
// ----------------------------------------------------------------
`define TCDC_MD_DST   5:4
`define TCDC_MD_SRC   3:2
`define TCDC_MD_BURST 1
`define TCDC_WC_IWI   5:4
`define TCDC_WC_SNS0  3
`define TCDC_WC_SNS1  2
`define TCDC_WC_DIR   1:0
// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define TCDC_AM_INC   2'h0
`define TCDC_AM_DEC   2'h1
`define TCDC_AM_IO    2'h3
`define TCDC_RST_IWI  2'h0
`define TCDC_RST_REQN 2'h3
`define TCDC_CNT_LAST 16'h0001
`define TCDC_CNT_ZERO 16'h0000
`define TCDC_RD_ZERO  32'h00000000
`endif

// ---- include/tcdc_pkg.sv ----
package tcdc_pkg;
  typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE} tcdc_fsm_e;

  typedef struct packed {
    logic [1:0]  de;
    logic [1:0]  die;
    logic        main_transfer_enable;
    logic [1:0]  dst;
    logic [1:0]  src;
    logic        burst;
    logic [1:0]  iwi;
    logic [1:0]  sns;
    logic [1:0]  dir;
    logic [19:0] chan0_source_address;
    logic [19:0] chan0_dest_address;
    logic [15:0] chan0_byte_count;
    logic [19:0] chan1_memory_address;
    logic [15:0] chan1_io_address;
    logic [15:0] chan1_byte_count;
    tcdc_fsm_e   fsm;
    logic        chan;
    logic [1:0]  waitc;
    logic        ack;
    logic [31:0] rdata;
    logic        nmi_s1;
    logic        nmi_s2;
    logic        nmi_prev;
  } tcdc_st_s;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] prev;
    logic [1:0] pend;
  } tcdc_det_s;
endpackage

// ---- include/tcdc_req_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface tcdc_req_if;
  logic [1:0] sense;
  logic [1:0] take;
  logic [1:0] want;
  modport det (input sense, input take, output want);
  modport ctl (output sense, output take, input want);
endinterface
`default_nettype wire

// ---- rtl/tcdc_req_detect.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tcdc_defs.svh"
module tcdc_req_detect (
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  // Request pins, active low
  input  wire logic [1:0] req_n_i,
  // Controller side
  tcdc_req_if.det     rq
);
  import tcdc_pkg::*;

  tcdc_det_s st;
  tcdc_det_s next_st;
  logic [1:0] fall;

  assign fall = st.prev & ~st.s2;

  always_comb begin
    next_st      = st;
    next_st.s1   = req_n_i;
    next_st.s2   = st.s1;
    next_st.prev = st.s2;
    // An edge landing on the consuming cycle stays pending
    next_st.pend = fall | (st.pend & ~rq.take);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st      <= '0;
      st.s1   <= `TCDC_RST_REQN;
      st.s2   <= `TCDC_RST_REQN;
      st.prev <= `TCDC_RST_REQN;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Level or falling-edge request per channel
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_want
    assign rq.want[i] = rq.sense[i] ? st.pend[i] : ~st.s2[i];
  end

  a_edge_pending : assert property (
    @(posedge clk_i) disable iff (rst_i)
    fall[0] |=> st.pend[0])
    else $error("falling edge not held pending");
endmodule
`default_nettype wire

// ---- rtl/tcdc_top.sv ----
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tcdc_defs.svh"
module tcdc_top (
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  // Avalon-MM register slave
  input  wire logic [7:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Pins from the outside world
  input  wire logic        NMI_N_I,
  input  wire logic        CHAN0_REQUEST_N_I,
  input  wire logic        CHAN1_REQUEST_N_I,
  output logic             CHAN0_TRANSFER_END_N_O,
  output logic             CHAN1_TRANSFER_END_N_O,
  output logic             IRQ_O,
  // Bus cycle requests toward the system bus
  output logic             DMA_BUS_OWN_O,
  output logic             CPU_PAUSE_O,
  output logic [19:0]      DMA_ADDR_O,
  output logic             DMA_RD_O,
  output logic             DMA_WR_O,
  output logic             DMA_IO_O,
  output logic [1:0]       IO_WAIT_COUNT_O
);
  import tcdc_pkg::*;

  tcdc_st_s    st;
  tcdc_st_s    next_st;
  tcdc_req_if  rq ();

  logic        nmi_hit;
  logic        mm0;
  logic        rsv0;
  logic        go0;
  logic        go1;
  logic        cur_io;
  logic [1:0]  wait_need;
  logic        sw_wr;
  logic        sw_rd;
  logic [31:0] old_v;
  logic [31:0] mrg;
  logic        last0;
  logic        last1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [19:0] f_step(input logic [19:0] a, input logic [1:0] m);
    case (m)
      `TCDC_AM_INC: f_step = a + 20'h00001;
      `TCDC_AM_DEC: f_step = a - 20'h00001;
      default:      f_step = a;
    endcase
  endfunction

  function automatic logic [31:0] f_merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
    f_merge = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        f_merge[b*8 +: 8] = n[b*8 +: 8];
      end
    end
  endfunction

  function automatic logic [31:0] f_rdata(input logic [7:0] a, input tcdc_st_s s);
    f_rdata = `TCDC_RD_ZERO;
    case (a)
      `TCDC_IDX_CHAN0_SOURCE_ADDRESS: f_rdata[19:0] = s.chan0_source_address;
      `TCDC_IDX_CHAN0_DEST_ADDRESS: f_rdata[19:0] = s.chan0_dest_address;
      `TCDC_IDX_CHAN0_BYTE_COUNT: f_rdata[15:0] = s.chan0_byte_count;
      `TCDC_IDX_CHAN1_MEMORY_ADDRESS: f_rdata[19:0] = s.chan1_memory_address;
      `TCDC_IDX_CHAN1_IO_ADDRESS: f_rdata[15:0] = s.chan1_io_address;
      `TCDC_IDX_CHAN1_BYTE_COUNT: f_rdata[15:0] = s.chan1_byte_count;
      // Strobe positions never store, so they always read one
      `TCDC_IDX_STAT: f_rdata[7:0] = {s.de[1], s.de[0], 2'h3, s.die[1], s.die[0],
                                      1'b0, s.main_transfer_enable};
      `TCDC_IDX_MODE: f_rdata[7:0] = {2'h0, s.dst, s.src, s.burst, 1'b0};
      `TCDC_IDX_WCTL: f_rdata[7:0] = {2'h0, s.iwi, s.sns[0], s.sns[1], s.dir};
      default:        f_rdata = `TCDC_RD_ZERO;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Request sensing
  // ----------------------------------------------------------------
  tcdc_req_detect u_det (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .req_n_i ({CHAN1_REQUEST_N_I, CHAN0_REQUEST_N_I}),
    .rq      (rq.det)
  );

  assign rq.sense = st.sns;
  assign rq.take  = (st.fsm == S_IDLE) ? {go1 & ~go0, go0} : 2'h0;

  // ----------------------------------------------------------------
  // Decode of the current channel setup
  // ----------------------------------------------------------------
  assign nmi_hit = st.nmi_prev & ~st.nmi_s2;
  assign mm0     = ~st.src[1] & ~st.dst[1];
  assign rsv0    = st.src[1] & st.dst[1];
  // Memory pairs run freely, any I/O side waits for a request
  assign go0     = st.de[0] & st.main_transfer_enable & ~rsv0 & (mm0 | rq.want[0]);
  assign go1     = st.de[1] & st.main_transfer_enable & rq.want[1];
  assign last0   = (st.chan0_byte_count == `TCDC_CNT_LAST);
  assign last1   = (st.chan1_byte_count == `TCDC_CNT_LAST);
  assign sw_wr   = AVS_WRITE_I & st.ack;
  assign sw_rd   = AVS_READ_I & ~st.ack;
  assign old_v   = f_rdata(AVS_ADDRESS_I, st);
  assign mrg     = f_merge(old_v, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);

  always_comb begin
    if (!st.chan) begin
      cur_io = (st.fsm == S_READ) ? (st.src == `TCDC_AM_IO) : (st.dst == `TCDC_AM_IO);
    end else begin
      cur_io = (st.fsm == S_READ) ? st.dir[1] : ~st.dir[1];
    end
  end

  assign wait_need = cur_io ? st.iwi : 2'h0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.nmi_s1   = NMI_N_I;
    next_st.nmi_s2   = st.nmi_s1;
    next_st.nmi_prev = st.nmi_s2;

    case (st.fsm)
      S_IDLE: begin
        next_st.waitc = 2'h0;
        if (go0) begin
          next_st.chan = 1'b0;
          next_st.fsm  = S_READ;
        end else if (go1) begin
          next_st.chan = 1'b1;
          next_st.fsm  = S_READ;
        end
      end
      S_READ: begin
        if (st.waitc != wait_need) begin
          next_st.waitc = st.waitc + 2'h1;
        end else begin
          next_st.waitc = 2'h0;
          next_st.fsm   = S_WRITE;
        end
      end
      S_WRITE: begin
        if (st.waitc != wait_need) begin
          next_st.waitc = st.waitc + 2'h1;
        end else begin
          next_st.waitc = 2'h0;
          next_st.fsm   = S_IDLE;
          if (!st.chan) begin
            next_st.chan0_byte_count = st.chan0_byte_count - 16'h0001;
            next_st.chan0_source_address = f_step(st.chan0_source_address, st.src);
            next_st.chan0_dest_address = f_step(st.chan0_dest_address, st.dst);
            if (last0) begin
              next_st.de[0] = 1'b0;
            end
            // Memory-to-memory burst keeps the bus; cycle steal hands one cycle back to the CPU
            if (mm0 && st.burst && !last0 && st.main_transfer_enable && !nmi_hit) begin
              next_st.fsm = S_READ;
            end
          end else begin
            next_st.chan1_byte_count = st.chan1_byte_count - 16'h0001;
            next_st.chan1_memory_address = f_step(st.chan1_memory_address, {1'b0, st.dir[0]});
            if (last1) begin
              next_st.de[1] = 1'b0;
            end
          end
        end
      end
      default: next_st.fsm = S_IDLE;
    endcase

    if (nmi_hit) begin
      next_st.main_transfer_enable = 1'b0;
    end

    // Software write lands last so it wins over the hardware clear
    if (sw_wr) begin
      case (AVS_ADDRESS_I)
        `TCDC_IDX_CHAN0_SOURCE_ADDRESS: next_st.chan0_source_address = mrg[19:0];
        `TCDC_IDX_CHAN0_DEST_ADDRESS: next_st.chan0_dest_address = mrg[19:0];
        `TCDC_IDX_CHAN0_BYTE_COUNT: next_st.chan0_byte_count = mrg[15:0];
        `TCDC_IDX_CHAN1_MEMORY_ADDRESS: next_st.chan1_memory_address = mrg[19:0];
        `TCDC_IDX_CHAN1_IO_ADDRESS: next_st.chan1_io_address = mrg[15:0];
        `TCDC_IDX_CHAN1_BYTE_COUNT: next_st.chan1_byte_count = mrg[15:0];
        `TCDC_IDX_STAT: begin
          if (AVS_BYTEENABLE_I[0]) begin
            next_st.die = {mrg[`TCDC_ST_CHAN0_TERM_IRQ_ENABLE + 1], mrg[`TCDC_ST_CHAN0_TERM_IRQ_ENABLE]};
            for (int i = 0; i < 2; i++) begin
              if (!mrg[`TCDC_ST_WE0 + i]) begin
                next_st.de[i] = mrg[`TCDC_ST_DE0 + i];
                if (mrg[`TCDC_ST_DE0 + i]) begin
                  next_st.main_transfer_enable = 1'b1;
                end
              end
            end
          end
        end
        `TCDC_IDX_MODE: begin
          if (AVS_BYTEENABLE_I[0]) begin
            next_st.dst   = mrg[`TCDC_MD_DST];
            next_st.src   = mrg[`TCDC_MD_SRC];
            next_st.burst = mrg[`TCDC_MD_BURST];
          end
        end
        `TCDC_IDX_WCTL: begin
          if (AVS_BYTEENABLE_I[0]) begin
            next_st.iwi    = mrg[`TCDC_WC_IWI];
            next_st.sns[0] = mrg[`TCDC_WC_SNS0];
            next_st.sns[1] = mrg[`TCDC_WC_SNS1];
            next_st.dir    = mrg[`TCDC_WC_DIR];
          end
        end
        default: ;
      endcase
    end

    // One wait cycle per access: data is captured, then presented
    next_st.ack = (AVS_READ_I | AVS_WRITE_I) & ~st.ack;
    if (sw_rd) begin
      next_st.rdata = old_v;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st          <= '0;
      st.iwi      <= `TCDC_RST_IWI;
      st.fsm      <= S_IDLE;
      st.nmi_s1   <= 1'b1;
      st.nmi_s2   <= 1'b1;
      st.nmi_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign AVS_READDATA_O    = st.rdata;
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~st.ack;
  assign IRQ_O             = |(st.die & ~st.de);
  assign IO_WAIT_COUNT_O   = st.iwi;
  assign DMA_BUS_OWN_O     = (st.fsm != S_IDLE);
  assign CPU_PAUSE_O       = (st.fsm != S_IDLE) & ~st.chan & mm0 & st.burst;
  assign DMA_RD_O          = (st.fsm == S_READ);
  assign DMA_WR_O          = (st.fsm == S_WRITE);
  assign DMA_IO_O          = (st.fsm != S_IDLE) & cur_io;
  assign CHAN0_TRANSFER_END_N_O = ~((st.fsm == S_WRITE) & ~st.chan & last0);
  assign CHAN1_TRANSFER_END_N_O = ~((st.fsm == S_WRITE) & st.chan & last1);

  always_comb begin
    if (!st.chan) begin
      DMA_ADDR_O = (st.fsm == S_READ) ? st.chan0_source_address : st.chan0_dest_address;
    end else if ((st.fsm == S_READ) == st.dir[1]) begin
      DMA_ADDR_O = {4'h0, st.chan1_io_address};
    end else begin
      DMA_ADDR_O = st.chan1_memory_address;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_strobe_read_one : assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == `TCDC_IDX_STAT)
      |-> AVS_READDATA_O[5:4] == 2'h3)
    else $error("strobe bits did not read one");

  a_strobe_blocks_de : assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (sw_wr && AVS_ADDRESS_I == `TCDC_IDX_STAT && mrg[`TCDC_ST_WE0] && !st.de[0])
      |=> !st.de[0])
    else $error("enable changed with strobe high");

  a_enable_sets_main : assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (sw_wr && AVS_ADDRESS_I == `TCDC_IDX_STAT && AVS_BYTEENABLE_I[0]
      && !mrg[`TCDC_ST_WE0] && mrg[`TCDC_ST_DE0]) |=> st.de[0] && st.main_transfer_enable)
    else $error("enable write did not set main enable");

  a_nmi_clears_main : assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (nmi_hit && !sw_wr) |=> !st.main_transfer_enable)
    else $error("nmi left main enable set");

  a_start_gated : assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st.fsm == S_IDLE && next_st.fsm == S_READ)
      |-> st.main_transfer_enable && st.de[next_st.chan] && !(next_st.chan == 1'b0 && rsv0))
    else $error("transfer started without enables");

  a_chan0_priority : assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st.fsm == S_IDLE && go0 && go1) |=> st.fsm == S_READ && !st.chan)
    else $error("channel 1 won a tie");

  a_irq_on_term : assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    ($fell(st.de[0]) && st.die[0]) |-> IRQ_O)
    else $error("termination did not raise interrupt");

  a_tend_last : assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    !CHAN0_TRANSFER_END_N_O |-> DMA_WR_O && st.chan0_byte_count == `TCDC_CNT_LAST)
    else $error("transfer end outside final write");

  a_term_clears_de : assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (st.fsm == S_WRITE && !st.chan && st.waitc == wait_need && last0 && !sw_wr)
      |=> !st.de[0] && st.chan0_byte_count == `TCDC_CNT_ZERO)
    else $error("final byte did not end channel 0");
endmodule
`default_nettype wire

// ---- verif/tcdc_periph.sv ----
`timescale 1ns/100ps
`default_nettype none
module tcdc_periph (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control from the bench
  input  wire logic [1:0] run_i,
  input  wire logic [1:0] edge_i,
  // Pins of the block
  input  wire logic [1:0] tend_n_i,
  output logic      [1:0] req_n_o
);
  logic [1:0] done;
  logic [2:0] ph;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done <= 2'h0;
      ph   <= 3'h0;
    end else begin
      // Assumes the shared pin is already switched to its transfer-end function
      done <= run_i & (done | ~tend_n_i);
      ph   <= ph + 3'h1;
    end
  end
  // Level: low until the last byte is flagged; edge: a fresh fall every 8 clocks
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      req_n_o[i] = ~(run_i[i] & ~done[i] & (~edge_i[i] | ph[2]));
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tcdc_defs.svh"
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        nmi_n = 1'b1;
  logic [1:0]  run = 2'h0;
  logic [1:0]  edg = 2'h0;
  logic [31:0] rdata;
  logic        wreq, irq, own, pause, drd, dwr, dio;
  logic [19:0] daddr;
  logic [1:0]  iwc, req_n, tend_n;
  int          n_errors = 0;
  int          cmp_count = 0;
  logic [63:0] rq[$];
  logic [22:0] wq[$];
  logic        prev_wr = 1'b0;
  logic        track = 1'b1;
  always #2 clk = ~clk;
  tcdc_top DUT (
    .SYS_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .NMI_N_I(nmi_n),
    .CHAN0_REQUEST_N_I(req_n[0]), .CHAN1_REQUEST_N_I(req_n[1]),
    .CHAN0_TRANSFER_END_N_O(tend_n[0]), .CHAN1_TRANSFER_END_N_O(tend_n[1]),
    .IRQ_O(irq), .DMA_BUS_OWN_O(own), .CPU_PAUSE_O(pause), .DMA_ADDR_O(daddr),
    .DMA_RD_O(drd), .DMA_WR_O(dwr), .DMA_IO_O(dio), .IO_WAIT_COUNT_O(iwc)
  );
  tcdc_periph PEER (.clk_i(clk), .rst_i(rst), .run_i(run), .edge_i(edg),
                    .tend_n_i(tend_n), .req_n_o(req_n));
  // --------------------------------
  // Checking and bus helpers
  // --------------------------------
  task automatic conclude;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic fail_out;
    n_errors++;
    $display("MISMATCH at %0t: wait ran out", $time);
    conclude();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] e, input logic [31:0] m);
    cmp_count++;
    if (((seen ^ e) & m) !== 32'h0) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, e);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic wt;
    n = 0;
    wt = 1'b1;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= ~w;
    while (wt !== 1'b0) begin
      @(posedge clk);
      wt = wreq;
      n++;
      if (n > 50) fail_out();
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({e, m});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic drain(input int left);
    int n;
    n = 0;
    while (wq.size() > left) begin
      @(posedge clk);
      n++;
      if (n > 2000) fail_out();
    end
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [19:0] step(input logic [1:0] m, input logic [19:0] a);
    return (m == 2'h0) ? a + 20'h1 : (m == 2'h1) ? a - 20'h1 : a;
  endfunction
  // --------------------------------
  // Result monitor
  // --------------------------------
  // Read data is taken at the rising edge that ends the read, a write phase at the first rising edge inside it
  always @(posedge clk) begin
    if (rd && wreq === 1'b0 && rq.size() > 0) begin
      chk(rdata, rq[0][63:32], rq[0][31:0]);
      void'(rq.pop_front());
    end
    if (dwr === 1'b1 && !prev_wr && track) begin
      if (wq.size() == 0) begin
        chk(32'h1, 32'h0, 32'h1);
      end else begin
        chk({9'h0, daddr, dio, tend_n}, {9'h0, wq.pop_front()}, 32'h7FFFFF);
      end
    end
    prev_wr = dwr;
  end
  initial begin
    #200000;
    fail_out();
  end
  // --------------------------------
  // Scenarios
  // --------------------------------
  initial begin
    logic [19:0] s, d;
    logic [15:0] io;
    logic [1:0]  dm, sm;
    logic [31:0] v;
    logic        bm;
    v = $urandom(32'h172d);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`TCDC_IDX_STAT, 32'h30, 32'hFD);
    rd_chk(`TCDC_IDX_MODE, 32'h00, 32'h3E);
    rd_chk(`TCDC_IDX_WCTL, 32'h00, 32'h3F);
    rd_chk(8'h40, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, `TCDC_IDX_STAT, 32'hFD);
    rd_chk(`TCDC_IDX_STAT, 32'h3C, 32'hFD);
    chk(32'(irq), 32'h1, 32'h1);
    bus(1'b1, `TCDC_IDX_STAT, 32'h30);
    @(negedge clk);
    chk(32'(irq), 32'h0, 32'h1);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      bus(1'b1, `TCDC_IDX_MODE, v);
      rd_chk(`TCDC_IDX_MODE, v, 32'h3E);
      bus(1'b1, `TCDC_IDX_WCTL, v);
      rd_chk(`TCDC_IDX_WCTL, v, 32'h3F);
      chk(32'(iwc), v >> 4, 32'h3);
    end
    // Reserved mode with the request pin active must stay off the bus
    bus(1'b1, `TCDC_IDX_MODE, 32'h28);
    bus(1'b1, `TCDC_IDX_CHAN0_BYTE_COUNT, 32'h2);
    run <= 2'b01;
    bus(1'b1, `TCDC_IDX_STAT, 32'h60);
    rd_chk(`TCDC_IDX_STAT, 32'h71, 32'hFD);
    repeat (30) @(posedge clk);
    chk(32'(own), 32'h0, 32'h1);
    run <= 2'b00;
    bus(1'b1, `TCDC_IDX_STAT, 32'h20);
    rd_chk(`TCDC_IDX_STAT, 32'h31, 32'hFD);
    for (int k = 0; k < 4; k++) begin
      dm = {1'b0, k[1]};
      sm = {1'b0, k[0]};
      bm = k[0] ^ k[1];
      s = 20'($urandom);
      d = 20'($urandom);
      bus(1'b1, `TCDC_IDX_CHAN0_SOURCE_ADDRESS, {12'h0, s});
      bus(1'b1, `TCDC_IDX_CHAN0_DEST_ADDRESS, {12'h0, d});
      bus(1'b1, `TCDC_IDX_CHAN0_BYTE_COUNT, 32'h3);
      bus(1'b1, `TCDC_IDX_MODE, {26'h0, dm, sm, bm, 1'b0});
      for (int b = 0; b < 3; b++) begin
        wq.push_back({d, 1'b0, (b == 2) ? 2'b10 : 2'b11});
        d = step(dm, d);
        s = step(sm, s);
      end
      bus(1'b1, `TCDC_IDX_STAT, 32'h64);
      @(negedge clk);
      chk(32'(own), 32'h0, 32'h1);
      @(negedge clk);
      chk(32'(drd), 32'h1, 32'h1);
      chk(32'(pause), 32'(bm), 32'h1);
      drain(0);
      rd_chk(`TCDC_IDX_CHAN0_SOURCE_ADDRESS, {12'h0, s}, 32'hFFFFF);
      rd_chk(`TCDC_IDX_CHAN0_DEST_ADDRESS, {12'h0, d}, 32'hFFFFF);
      rd_chk(`TCDC_IDX_CHAN0_BYTE_COUNT, 32'h0, 32'hFFFF);
      rd_chk(`TCDC_IDX_STAT, 32'h35, 32'hFD);
      chk(32'(irq), 32'h1, 32'h1);
    end
    // Abort by NMI in mid-run, then restart by an enable write
    track = 1'b0;
    bus(1'b1, `TCDC_IDX_CHAN0_BYTE_COUNT, 32'h28);
    bus(1'b1, `TCDC_IDX_MODE, 32'h00);
    bus(1'b1, `TCDC_IDX_STAT, 32'h60);
    @(negedge clk);
    chk(32'(irq), 32'h0, 32'h1);
    repeat (10) @(posedge clk);
    nmi_n <= 1'b0;
    repeat (4) @(posedge clk);
    nmi_n <= 1'b1;
    repeat (12) @(posedge clk);
    chk(32'(own), 32'h0, 32'h1);
    rd_chk(`TCDC_IDX_STAT, 32'h70, 32'hFD);
    bus(1'b1, `TCDC_IDX_STAT, 32'h64);
    for (int n = 0; irq !== 1'b1; n++) begin
      @(posedge clk);
      if (n > 1000) fail_out();
    end
    rd_chk(`TCDC_IDX_CHAN0_BYTE_COUNT, 32'h0, 32'hFFFF);
    track = 1'b1;
    // Both channels against the request pins, level and edge sensed
    for (int k = 0; k < 4; k++) begin
      io = 16'($urandom);
      s = 20'($urandom);
      d = 20'($urandom);
      bus(1'b1, `TCDC_IDX_CHAN0_SOURCE_ADDRESS, {12'h0, s});
      bus(1'b1, `TCDC_IDX_CHAN0_DEST_ADDRESS, {16'h0, io});
      bus(1'b1, `TCDC_IDX_CHAN0_BYTE_COUNT, 32'h2);
      bus(1'b1, `TCDC_IDX_MODE, 32'h30);
      bus(1'b1, `TCDC_IDX_CHAN1_MEMORY_ADDRESS, {12'h0, d});
      bus(1'b1, `TCDC_IDX_CHAN1_IO_ADDRESS, {16'h0, io});
      bus(1'b1, `TCDC_IDX_CHAN1_BYTE_COUNT, 32'h2);
      bus(1'b1, `TCDC_IDX_WCTL, {26'h0, 2'($urandom), k[0], k[0], k[1:0]});
      edg <= {k[0], k[0]};
      for (int b = 0; b < 2; b++) begin
        wq.push_back({4'h0, io, 1'b1, (b == 1) ? 2'b10 : 2'b11});
      end
      for (int b = 0; b < 2; b++) begin
        if (k < 2) begin
          wq.push_back({4'h0, io, 1'b1, (b == 1) ? 2'b01 : 2'b11});
        end else begin
          wq.push_back({d, 1'b0, (b == 1) ? 2'b01 : 2'b11});
        end
        d = step({1'b0, k[0]}, d);
      end
      bus(1'b1, `TCDC_IDX_STAT, 32'hC0);
      repeat (20) @(posedge clk);
      if (!k[0]) chk(32'(own), 32'h0, 32'h1);
      run <= k[0] ? 2'b01 : 2'b11;
      drain(2);
      run <= 2'b11;
      drain(0);
      run <= 2'b00;
      rd_chk(`TCDC_IDX_CHAN1_MEMORY_ADDRESS, {12'h0, d}, 32'hFFFFF);
      rd_chk(`TCDC_IDX_CHAN1_BYTE_COUNT, 32'h0, 32'hFFFF);
      rd_chk(`TCDC_IDX_STAT, 32'h31, 32'hFD);
    end
    conclude();
  end
endmodule
`default_nettype wire
